// ==== rtl/psrc_axi_slave.sv ====
module psrc_axi_slave
  import psrc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // write channels
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  output logic wr_go,
  output logic [11:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic [11:0] rd_addr,
  input wire logic [31:0] rd_value,
  input wire logic rd_hit,
  input wire logic wr_hit
);
  logic aw_held_r;
  logic w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  assign awready = ce && !aw_held_r && !bvalid_r;
  assign wready = ce && !w_held_r && !bvalid_r;
  assign arready = ce && !rvalid_r;
  assign wr_go = ce && aw_held_r && w_held_r && !bvalid_r;
  assign wr_addr = awaddr_r;
  assign wr_data = wdata_r;
  assign wr_strb = wstrb_r;
  assign rd_addr = araddr;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= PSRC_RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? PSRC_RESP_OKAY : PSRC_RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= PSRC_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_hit ? rd_value : 32'h00000000;
        rresp_r <= rd_hit ? PSRC_RESP_OKAY : PSRC_RESP_SLVERR;
      end else if (rvalid_r && rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end
endmodule : psrc_axi_slave

// ==== rtl/psrc_pkg.sv ====
package psrc_pkg;
  localparam int unsigned PSRC_DW = 32;
  localparam int unsigned PSRC_AW = 12;
  localparam logic [11:0] PSRC_OFF_A = 12'h040;
  localparam logic [11:0] PSRC_OFF_B = 12'h044;
  localparam logic [11:0] PSRC_OFF_C = 12'h048;
  localparam logic [31:0] PSRC_RST_VAL = 32'h00000000;
  // writable field masks of the first and second reset registers
  localparam logic [31:0] PSRC_MASK_A = 32'h07000048;
  localparam logic [31:0] PSRC_MASK_B = 32'h000F1033;
  // field positions
  localparam int unsigned PSRC_A_BUS0 = 24;
  localparam int unsigned PSRC_A_SLEEP = 6;
  localparam int unsigned PSRC_A_WDOG = 3;
  localparam int unsigned PSRC_B_CNT0 = 16;
  localparam int unsigned PSRC_B_TWI = 12;
  localparam int unsigned PSRC_B_SYNC_SERIAL_A_RESET = 4;
  localparam int unsigned PSRC_B_SER0 = 0;
  localparam logic [1:0] PSRC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PSRC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] bus_ctrl;
    logic sleep_module;
    logic watchdog_unit;
    logic [3:0] counter;
    logic two_wire_ctrl;
    logic [1:0] sync_serial;
    logic [1:0] serial_port;
  } psrc_resets_t;

  typedef struct packed {
    logic [31:0] cap_one;
    logic [31:0] cap_two;
    logic [31:0] cap_four;
  } psrc_caps_t;
endpackage : psrc_pkg

// ==== rtl/psrc_reg.sv ====
module psrc_reg
  import psrc_pkg::*;
#(
  parameter logic [31:0] MASK = 32'hFFFFFFFF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // write side
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_strb,
  input wire logic [31:0] cap,
  // state
  output logic [31:0] value
);
  logic [31:0] value_r;
  logic [31:0] value_nxt;
  logic [31:0] lane_en;

  assign lane_en = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  // absent units and unassigned bits stay zero whatever is written
  assign value_nxt = (((wr_data & lane_en) | (value_r & ~lane_en)) & cap & MASK);
  assign value = value_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      value_r <= PSRC_RST_VAL;
    end else if (ce && wr_en) begin
      value_r <= value_nxt;
    end
  end

  // checked after each write only: a later drop of a capability leaves old bits alone
  property p_absent_zero;
    @(posedge clk) disable iff (!rst_b)
    (ce && wr_en) |=> (value_r & ~($past(cap) & MASK)) == 32'h00000000;
  endproperty : p_absent_zero
  a_absent_zero: assert property (p_absent_zero) else $error("absent unit bit set");
endmodule : psrc_reg

// ==== rtl/psrc_top.sv ====
// Behaviour
// - writes to both reset registers and the third register are masked by capability registers one, two and four.
// - bits 26..24 of the first register reset bus controllers c, b and a.
// - bit 6 of the first register resets the sleep module.
// - bit 3 of the first register resets the watchdog unit.
// - bits 19..16 of the second register reset counters d down to a.
// - bit 12 of the second register resets the two-wire controller.
// - bits 5 and 4 of the second register reset sync serial units b and a.
// - bits 1 and 0 of the second register reset serial ports b and a.
// - both registers are 32 bits, read/write, and clear to zero on reset.
// - unassigned bits read zero and ignore writes; software preserves them.
//
// Register access over AXI4-Lite was left to the implementer.
module psrc_top
  import psrc_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // capability registers, from system control
  input wire psrc_caps_t caps,
  // per-unit reset outputs, high holds the unit in reset
  output psrc_resets_t unit_resets
);
  logic wr_go;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [11:0] rd_addr;
  logic [31:0] rd_value;
  logic rd_hit;
  logic wr_hit;
  logic [31:0] reg_a;
  logic [31:0] reg_b;
  logic [31:0] reg_c;
  logic wr_a;
  logic wr_b;
  logic wr_c;
  logic sel_rd_a;
  logic sel_rd_b;
  logic sel_rd_c;
  psrc_resets_t resets_r;
  psrc_resets_t resets_nxt;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = (a[11:2] == off[11:2]);
  endfunction : addr_is

  psrc_axi_slave u_bus (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_go(wr_go),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .rd_value(rd_value),
    .rd_hit(rd_hit),
    .wr_hit(wr_hit)
  );

  assign wr_a = wr_go && addr_is(wr_addr, PSRC_OFF_A);
  assign wr_b = wr_go && addr_is(wr_addr, PSRC_OFF_B);
  assign wr_c = wr_go && addr_is(wr_addr, PSRC_OFF_C);
  assign wr_hit = addr_is(wr_addr, PSRC_OFF_A) || addr_is(wr_addr, PSRC_OFF_B)
    || addr_is(wr_addr, PSRC_OFF_C);
  assign sel_rd_a = addr_is(rd_addr, PSRC_OFF_A);
  assign sel_rd_b = addr_is(rd_addr, PSRC_OFF_B);
  assign sel_rd_c = addr_is(rd_addr, PSRC_OFF_C);
  assign rd_hit = sel_rd_a || sel_rd_b || sel_rd_c;
  assign rd_value = sel_rd_a ? reg_a : (sel_rd_b ? reg_b : (sel_rd_c ? reg_c : 32'h00000000));

  psrc_reg #(.MASK(PSRC_MASK_A)) u_reg_a (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .wr_en(wr_a),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .cap(caps.cap_one),
    .value(reg_a)
  );

  psrc_reg #(.MASK(PSRC_MASK_B)) u_reg_b (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .wr_en(wr_b),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .cap(caps.cap_two),
    .value(reg_b)
  );

  // third register's field layout is not defined here: mask by capability only
  psrc_reg #(.MASK(32'hFFFFFFFF)) u_reg_c (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .wr_en(wr_c),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .cap(caps.cap_four),
    .value(reg_c)
  );

  assign resets_nxt.bus_ctrl = reg_a[PSRC_A_BUS0 +: 3];
  assign resets_nxt.sleep_module = reg_a[PSRC_A_SLEEP];
  assign resets_nxt.watchdog_unit = reg_a[PSRC_A_WDOG];
  assign resets_nxt.counter = reg_b[PSRC_B_CNT0 +: 4];
  assign resets_nxt.two_wire_ctrl = reg_b[PSRC_B_TWI];
  assign resets_nxt.sync_serial = reg_b[PSRC_B_SYNC_SERIAL_A_RESET +: 2];
  assign resets_nxt.serial_port = reg_b[PSRC_B_SER0 +: 2];

  // registered so the reset lines are glitch free toward the units
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resets_r <= '0;
    end else if (ce) begin
      resets_r <= resets_nxt;
    end
  end
  assign unit_resets = resets_r;

  property p_bus_map;
    @(posedge clk) disable iff (!rst_b)
    ce |=> unit_resets.bus_ctrl == $past(reg_a[26:24]);
  endproperty : p_bus_map
  a_bus_map: assert property (p_bus_map) else $error("bus ctrl reset mismatch");

  property p_sleep_map;
    @(posedge clk) disable iff (!rst_b)
    ce |=> unit_resets.sleep_module == $past(reg_a[6]);
  endproperty : p_sleep_map
  a_sleep_map: assert property (p_sleep_map) else $error("sleep reset mismatch");

  property p_wdog_map;
    @(posedge clk) disable iff (!rst_b)
    ce |=> unit_resets.watchdog_unit == $past(reg_a[3]);
  endproperty : p_wdog_map
  a_wdog_map: assert property (p_wdog_map) else $error("watchdog reset mismatch");

  property p_cnt_map;
    @(posedge clk) disable iff (!rst_b)
    ce |=> unit_resets.counter == $past(reg_b[19:16]);
  endproperty : p_cnt_map
  a_cnt_map: assert property (p_cnt_map) else $error("counter reset mismatch");

  property p_twi_map;
    @(posedge clk) disable iff (!rst_b)
    ce |=> unit_resets.two_wire_ctrl == $past(reg_b[12]);
  endproperty : p_twi_map
  a_twi_map: assert property (p_twi_map) else $error("two-wire reset mismatch");

  property p_ssi_map;
    @(posedge clk) disable iff (!rst_b)
    ce |=> unit_resets.sync_serial == $past(reg_b[5:4]);
  endproperty : p_ssi_map
  a_ssi_map: assert property (p_ssi_map) else $error("sync serial reset mismatch");

  property p_ser_map;
    @(posedge clk) disable iff (!rst_b)
    ce |=> unit_resets.serial_port == $past(reg_b[1:0]);
  endproperty : p_ser_map
  a_ser_map: assert property (p_ser_map) else $error("serial port reset mismatch");

  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_b)
    (reg_a & ~PSRC_MASK_A) == 32'h00000000 &&
      (reg_b & ~PSRC_MASK_B) == 32'h00000000;
  endproperty : p_reserved_zero
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_write_masked;
    @(posedge clk) disable iff (!rst_b)
    (wr_b && wr_strb == 4'hF) |=>
      reg_b == ($past(wr_data) & $past(caps.cap_two) & PSRC_MASK_B);
  endproperty : p_write_masked
  a_write_masked: assert property (p_write_masked) else $error("masked write wrong");

  property p_hold_no_write;
    @(posedge clk) disable iff (!rst_b)
    (!wr_a && $stable(caps.cap_one)) |=> $stable(reg_a);
  endproperty : p_hold_no_write
  a_hold_no_write: assert property (p_hold_no_write) else $error("register changed");

  property p_bad_addr_err;
    @(posedge clk) disable iff (!rst_b)
    (ce && arvalid && arready && !rd_hit) |=> rvalid && rresp == PSRC_RESP_SLVERR;
  endproperty : p_bad_addr_err
  a_bad_addr_err: assert property (p_bad_addr_err) else $error("unmapped read not refused");

  // no disable here: checks the state that the reset itself leaves behind
  property p_reset_clear;
    @(posedge clk)
    !rst_b |=> reg_a == PSRC_RST_VAL && reg_b == PSRC_RST_VAL && reg_c == PSRC_RST_VAL
      && unit_resets == '0;
  endproperty : p_reset_clear
  a_reset_clear: assert property (p_reset_clear) else $error("not cleared by reset");

  property p_write_masked_a;
    @(posedge clk) disable iff (!rst_b)
    (wr_a && wr_strb == 4'hF) |=>
      reg_a == ($past(wr_data) & $past(caps.cap_one) & PSRC_MASK_A);
  endproperty : p_write_masked_a
  a_write_masked_a: assert property (p_write_masked_a) else $error("write a wrong");

  property p_write_masked_c;
    @(posedge clk) disable iff (!rst_b)
    (wr_c && wr_strb == 4'hF) |=>
      reg_c == ($past(wr_data) & $past(caps.cap_four));
  endproperty : p_write_masked_c
  a_write_masked_c: assert property (p_write_masked_c) else $error("write c wrong");

  property p_absent_a;
    @(posedge clk) disable iff (!rst_b)
    wr_a |=> (reg_a & ~$past(caps.cap_one)) == 32'h00000000;
  endproperty : p_absent_a
  a_absent_a: assert property (p_absent_a) else $error("absent unit bit set");

  property p_bad_wr_err;
    @(posedge clk) disable iff (!rst_b)
    (wr_go && !wr_hit) |=> bvalid && bresp == PSRC_RESP_SLVERR;
  endproperty : p_bad_wr_err
  a_bad_wr_err: assert property (p_bad_wr_err) else $error("unmapped write not refused");

  property p_bad_wr_keep;
    @(posedge clk) disable iff (!rst_b)
    (wr_go && !wr_hit) |=>
      $stable(reg_a) && $stable(reg_b) && $stable(reg_c);
  endproperty : p_bad_wr_keep
  a_bad_wr_keep: assert property (p_bad_wr_keep) else $error("unmapped write landed");

  property p_write_busy;
    @(posedge clk) disable iff (!rst_b)
    bvalid |-> !awready && !wready;
  endproperty : p_write_busy
  a_write_busy: assert property (p_write_busy) else $error("write taken while busy");

  property p_read_busy;
    @(posedge clk) disable iff (!rst_b)
    rvalid |-> !arready;
  endproperty : p_read_busy
  a_read_busy: assert property (p_read_busy) else $error("read taken while busy");

  property p_ce_freeze;
    @(posedge clk) disable iff (!rst_b)
    !ce |=> $stable(unit_resets) && $stable(reg_a) && $stable(reg_b)
      && $stable(reg_c);
  endproperty : p_ce_freeze
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while disabled");

  property p_read_a;
    @(posedge clk) disable iff (!rst_b)
    (arvalid && arready && sel_rd_a) |=>
      rvalid && rdata == $past(reg_a) && rresp == PSRC_RESP_OKAY;
  endproperty : p_read_a
  a_read_a: assert property (p_read_a) else $error("read a wrong");

  property p_read_b;
    @(posedge clk) disable iff (!rst_b)
    (arvalid && arready && sel_rd_b) |=>
      rvalid && rdata == $past(reg_b) && rresp == PSRC_RESP_OKAY;
  endproperty : p_read_b
  a_read_b: assert property (p_read_b) else $error("read b wrong");

  property p_read_c;
    @(posedge clk) disable iff (!rst_b)
    (arvalid && arready && sel_rd_c) |=>
      rvalid && rdata == $past(reg_c) && rresp == PSRC_RESP_OKAY;
  endproperty : p_read_c
  a_read_c: assert property (p_read_c) else $error("read c wrong");

  property p_release;
    @(posedge clk) disable iff (!rst_b)
    (ce && $fell(reg_a[PSRC_A_WDOG])) |=> !unit_resets.watchdog_unit;
  endproperty : p_release
  a_release: assert property (p_release) else $error("watchdog not released");
endmodule : psrc_top

// ==== tb/psrc_tb_top.sv ====
module psrc_tb_top
  import psrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  psrc_caps_t caps = '0;
  psrc_resets_t unit_resets;
  int err_count = 0;
  int n_compared = 0;
  integer seed = 32'hAB34;
  logic [31:0] m [3];
  logic [1:0] rsp;
  logic [31:0] rd;

  always #12.5 clk = ~clk;

  psrc_top u_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .caps(caps), .unit_resets(unit_resets));

  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // entered and left just after a rising edge; handshakes judged before the next edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    int n;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hs = 1'b0;
    for (n = 0; n < 100 && !b_hs; n++) begin
      @(negedge clk);
      aw_hs = awvalid & awready;
      w_hs = wvalid & wready;
      b_hs = bvalid & bready;
      r = bresp;
      @(posedge clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) bready <= 1'b0;
    end
    if (!b_hs) chk("bvalid", 32'h0, 32'h1);
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hs = 1'b0;
    for (n = 0; n < 100 && !r_hs; n++) begin
      @(negedge clk);
      ar_hs = arvalid & arready;
      r_hs = rvalid & rready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) rready <= 1'b0;
    end
    if (!r_hs) chk("rvalid", 32'h0, 32'h1);
    @(posedge clk);
  endtask : axi_rd

  function automatic logic [11:0] off(input int k);
    return (k == 0) ? PSRC_OFF_A : (k == 1) ? PSRC_OFF_B : PSRC_OFF_C;
  endfunction : off

  // every write re-gates the whole word, unstrobed lanes too
  function automatic logic [31:0] wmask(input int k);
    return (k == 0) ? (PSRC_MASK_A & caps.cap_one) :
      (k == 1) ? (PSRC_MASK_B & caps.cap_two) : caps.cap_four;
  endfunction : wmask

  function automatic psrc_resets_t exp_res(input logic [31:0] a, input logic [31:0] b);
    psrc_resets_t r;
    r.bus_ctrl = a[26:24];
    r.sleep_module = a[6];
    r.watchdog_unit = a[3];
    r.counter = b[19:16];
    r.two_wire_ctrl = b[12];
    r.sync_serial = b[5:4];
    r.serial_port = b[1:0];
    return r;
  endfunction : exp_res

  task automatic check_all();
    for (int k = 0; k < 3; k++) begin
      axi_rd(off(k), rd, rsp);
      chk("rdata", rd, m[k]);
      chk("rresp", {30'h0, rsp}, {30'h0, PSRC_RESP_OKAY});
    end
    chk("unit_resets", 32'(unit_resets), 32'(exp_res(m[0], m[1])));
  endtask : check_all

  task automatic do_wr(input int k, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] bm;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    axi_wr(off(k), d, s, rsp);
    chk("bresp", {30'h0, rsp}, {30'h0, PSRC_RESP_OKAY});
    m[k] = ((m[k] & ~bm) | (d & bm)) & wmask(k);
    axi_rd(off(k), rd, rsp);
    chk("rdata", rd, m[k]);
    chk("unit_resets", 32'(unit_resets), 32'(exp_res(m[0], m[1])));
  endtask : do_wr

  initial begin
    repeat (50000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  initial begin
    m = '{default: 32'h0};
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check_all();
    for (int i = 0; i < 40; i++) begin
      if (i == 0) caps <= '1;
      else if (i == 1) caps <= '0;
      else caps <= {$random(seed), $random(seed), $random(seed)};
      @(posedge clk);
      for (int k = 0; k < 3; k++) begin
        do_wr(k, (i < 2) ? 32'hFFFFFFFF : $random(seed), 4'hF);
        do_wr(k, $random(seed), 4'($random(seed)));
      end
      check_all();
    end
    // unmapped places answer with an error and change nothing
    axi_wr(12'h04C, 32'hFFFFFFFF, 4'hF, rsp);
    chk("bresp", {30'h0, rsp}, {30'h0, PSRC_RESP_SLVERR});
    axi_rd(12'h000, rd, rsp);
    chk("rresp", {30'h0, rsp}, {30'h0, PSRC_RESP_SLVERR});
    chk("rdata", rd, 32'h00000000);
    check_all();
    // enable low: no handshake offered, state frozen
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    chk("awready", {31'h0, awready}, 32'h0);
    chk("arready", {31'h0, arready}, 32'h0);
    chk("unit_resets", 32'(unit_resets), 32'(exp_res(m[0], m[1])));
    ce <= 1'b1;
    @(posedge clk);
    check_all();
    // reset in mid-run clears everything
    caps <= '1;
    @(posedge clk);
    do_wr(0, 32'hFFFFFFFF, 4'hF);
    do_wr(1, 32'hFFFFFFFF, 4'hF);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    chk("unit_resets", 32'(unit_resets), 32'h0);
    rst_b <= 1'b1;
    @(posedge clk);
    m = '{default: 32'h0};
    check_all();
    end_of_test();
  end
endmodule : psrc_tb_top
